// File: include/soa_regs.svh
// register indices, field positions and reset values of the interrupt aggregator
// Summary of operation
// - path status bit changes set source bits; reading path status clears them
// - change in filtered three-bit remote-defect field sets a bit; reading field clears it
// - path remote-error and parity counter rollovers set bits; counter read clears
// - receive FIFO overrun sets bit while retiming enabled; retiming source read clears
// - transmit justification counter rollovers set bits; each counter read clears
// - transmit FIFO overrun sets bit; transmit source read clears it
// - transmit bus parity errors counted; third sets bit; transmit read clears both
// - global summary shows one pending bit per source register, transmit at bit 7
// - interrupt output high while any source bit and its enable are set
// - all interrupt enable bits reset to zero
// - enable registers mirror source layout; regenerator group enables at B0H-B2H
// - path, retiming and transmit source bits reset to zero, software read-only
// - protection, adaptation, path, retiming, transmit enables at B3H-B6H and E1H
// - overflow and byte-change bits have no status; counter or byte is status
`ifndef SOA_REGS_SVH
`define SOA_REGS_SVH

`define SOA_IDX_RDI_FIELD 8'h85
`define SOA_IDX_PATH_SRC 8'ha5
`define SOA_IDX_RETIME_SRC 8'ha6
`define SOA_IDX_EN_REGEN 8'hb0
`define SOA_IDX_EN_RGMUX 8'hb1
`define SOA_IDX_EN_MUX 8'hb2
`define SOA_IDX_EN_PROT 8'hb3
`define SOA_IDX_EN_ADAP 8'hb4
`define SOA_IDX_EN_PATH 8'hb5
`define SOA_IDX_EN_RETIME 8'hb6
`define SOA_IDX_PATH_STATUS 8'hc5
`define SOA_IDX_GLOBAL 8'hd1
`define SOA_IDX_XMT_SRC 8'he0
`define SOA_IDX_EN_XMT 8'he1
`define SOA_IDX_CNT_REI 8'hf0
`define SOA_IDX_CNT_B3 8'hf1
`define SOA_IDX_CNT_TXNEG 8'hf2
`define SOA_IDX_CNT_TXPOS 8'hf3

`define SOA_PATH_MISMATCH_BIT 7
`define SOA_PATH_CRC_BIT 6
`define SOA_PATH_UNEQ_BIT 5
`define SOA_PATH_LABEL_BIT 4
`define SOA_PATH_RDI_BIT 3
`define SOA_PATH_LOM_BIT 2
`define SOA_PATH_REI_BIT 1
`define SOA_PATH_B3_BIT 0
`define SOA_RDI_FIELD_LSB 1
`define SOA_XMT_NEG_BIT 3
`define SOA_XMT_POS_BIT 2
`define SOA_XMT_FIFO_BIT 1
`define SOA_XMT_PAR_BIT 0

`define SOA_ENABLE_RESET 8'h00
`define SOA_SOURCE_RESET 8'h00
`define SOA_PARITY_LIMIT 2'h3

`endif

// File: include/soa_pkg.sv
// types shared by the interrupt aggregator modules
package soa_pkg;

    typedef enum logic [1:0] {
        SOA_BUS_IDLE = 2'b01,
        SOA_BUS_ANSWER = 2'b10
    } soa_bus_st_t;

    typedef struct packed {
        soa_bus_st_t bus;
        logic [31:0] rdata;
        logic slverr;
        logic irq;
        logic [7:0] en_regen;
        logic [7:0] en_rgmux;
        logic [7:0] en_mux;
        logic [7:0] en_prot;
        logic [7:0] en_adap;
        logic [7:0] en_path;
        logic [7:0] en_retime;
        logic [7:0] en_xmt;
        logic [4:0] status_prev;
        logic [2:0] rdi_prev;
        logic primed;
        logic [3:0] cnt_read;
    } soa_state_t;

    typedef struct packed {
        logic [1:0] cnt;
    } soa_par_state_t;

endpackage

// File: rtl/soa_sticky.sv
// sticky event bits with per-bit clear, set dominating clear
`timescale 1ns/1ps
`include "soa_regs.svh"
module soa_sticky #(
    parameter int W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] bits;
    } soa_sticky_state_t;

    soa_sticky_state_t st_ff;
    soa_sticky_state_t nxt_st;

    initial begin
        if (W < 1 || W > 8) begin
            $error("soa_sticky width out of range");
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.bits = (st_ff.bits & ~clr) | set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff.bits <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.bits;
endmodule

// File: rtl/soa_par_count.sv
// parity error counter on the transmit telecom bus byte
`timescale 1ns/1ps
`include "soa_regs.svh"
module soa_par_count (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] tx_telecom_bus_byte,
    input wire logic tx_bus_parity,
    input wire logic tx_bus_valid,
    input wire logic clear,
    output logic overrun_evt
);
    soa_pkg::soa_par_state_t st_ff;
    soa_pkg::soa_par_state_t nxt_st;
    logic err;

    // odd parity over byte and parity bit
    assign err = tx_bus_valid && !(^{tx_telecom_bus_byte, tx_bus_parity});
    // pulse on the error that brings the count to the limit
    assign overrun_evt = err && (st_ff.cnt == `SOA_PARITY_LIMIT - 2'h1);

    always_comb begin
        nxt_st = st_ff;
        if (clear) begin
            // an error in the clearing cycle is kept as the first of a new count
            nxt_st.cnt = err ? 2'h1 : 2'h0;
        end else if (err && st_ff.cnt != `SOA_PARITY_LIMIT) begin
            nxt_st.cnt = st_ff.cnt + 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff.cnt <= 2'h0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

// File: rtl/soa_irq_aggregator.sv
// interrupt source, enable and summary registers with apb slave
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`include "soa_regs.svh"
module soa_irq_aggregator #(
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic path_trace_mismatch_status,
    input wire logic path_trace_crc_status,
    input wire logic path_unequipped_status,
    input wire logic path_label_mismatch_status,
    input wire logic loss_of_multiframe_status,
    input wire logic [2:0] remote_defect_field,
    input wire logic path_remote_error_wrap,
    input wire logic path_parity_wrap,
    input wire logic receive_fifo_overrun,
    input wire logic receive_retiming_off,
    input wire logic tx_negative_justify_wrap,
    input wire logic tx_positive_justify_wrap,
    input wire logic transmit_fifo_overrun,
    input wire logic [7:0] tx_telecom_bus_byte,
    input wire logic tx_bus_parity,
    input wire logic tx_bus_valid,
    input wire logic [CNT_W-1:0] path_remote_error_counter,
    input wire logic [CNT_W-1:0] path_parity_error_counter,
    input wire logic [CNT_W-1:0] tx_negative_justify_counter,
    input wire logic [CNT_W-1:0] tx_positive_justify_counter,
    input wire logic [7:0] regen_irq_source_in,
    input wire logic [7:0] regen_mux_irq_source_in,
    input wire logic [7:0] mux_irq_source_in,
    input wire logic [7:0] protection_irq_source_in,
    input wire logic [7:0] adaptation_irq_source_in,
    output logic [3:0] counter_read
);
    soa_pkg::soa_state_t st_ff;
    soa_pkg::soa_state_t nxt_st;

    logic [7:0] path_set;
    logic [7:0] path_clr;
    logic [7:0] path_src;
    logic [0:0] retime_set;
    logic [0:0] retime_clr;
    logic [0:0] retime_src;
    logic [3:0] xmt_set;
    logic [3:0] xmt_clr;
    logic [3:0] xmt_src;
    logic parity_evt;
    logic [4:0] status_now;
    logic [4:0] status_chg;
    logic rdi_chg;
    logic capture;
    logic commit;
    logic [7:0] summary;
    logic [7:0] retime_byte;
    logic [7:0] xmt_byte;
    logic [7:0] status_byte;
    logic [7:0] rdi_byte;
    logic pending;

    initial begin
        if (CNT_W < 1 || CNT_W > 32) begin
            $error("soa_irq_aggregator CNT_W out of range");
        end
        if (`SOA_PARITY_LIMIT == 2'h0) begin
            $error("soa_irq_aggregator parity limit must be non-zero");
        end
    end

    // word-aligned hit on a register index; byte address is four times the index
    function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
        hit = (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
    endfunction

    function automatic logic [31:0] cnt_word(input logic [CNT_W-1:0] c);
        logic [31:0] w;
        w = '0;
        w[CNT_W-1:0] = c;
        cnt_word = w;
    endfunction

    // unmapped addresses answer with slverr and change nothing
    function automatic logic mapped(input logic [11:0] addr);
        mapped = hit(addr, `SOA_IDX_RDI_FIELD) || hit(addr, `SOA_IDX_PATH_SRC)
            || hit(addr, `SOA_IDX_RETIME_SRC) || hit(addr, `SOA_IDX_EN_REGEN)
            || hit(addr, `SOA_IDX_EN_RGMUX) || hit(addr, `SOA_IDX_EN_MUX)
            || hit(addr, `SOA_IDX_EN_PROT) || hit(addr, `SOA_IDX_EN_ADAP)
            || hit(addr, `SOA_IDX_EN_PATH) || hit(addr, `SOA_IDX_EN_RETIME)
            || hit(addr, `SOA_IDX_PATH_STATUS) || hit(addr, `SOA_IDX_GLOBAL)
            || hit(addr, `SOA_IDX_XMT_SRC) || hit(addr, `SOA_IDX_EN_XMT)
            || hit(addr, `SOA_IDX_CNT_REI) || hit(addr, `SOA_IDX_CNT_B3)
            || hit(addr, `SOA_IDX_CNT_TXNEG) || hit(addr, `SOA_IDX_CNT_TXPOS);
    endfunction

    // first access cycle latches read data and fires read side effects;
    // the following cycle answers, which keeps prdata on a flop
    assign capture = psel && penable && (st_ff.bus == soa_pkg::SOA_BUS_IDLE);
    assign commit = psel && penable && (st_ff.bus == soa_pkg::SOA_BUS_ANSWER);

    assign status_now = {path_trace_mismatch_status, path_trace_crc_status,
        path_unequipped_status, path_label_mismatch_status, loss_of_multiframe_status};
    // no change is reported on the first cycle after reset, the previous copy is unknown
    assign status_chg = st_ff.primed ? (status_now ^ st_ff.status_prev) : 5'h00;
    assign rdi_chg = st_ff.primed && (remote_defect_field != st_ff.rdi_prev);

    always_comb begin
        path_set = 8'h00;
        path_set[`SOA_PATH_MISMATCH_BIT] = status_chg[4];
        path_set[`SOA_PATH_CRC_BIT] = status_chg[3];
        path_set[`SOA_PATH_UNEQ_BIT] = status_chg[2];
        path_set[`SOA_PATH_LABEL_BIT] = status_chg[1];
        path_set[`SOA_PATH_LOM_BIT] = status_chg[0];
        path_set[`SOA_PATH_RDI_BIT] = rdi_chg;
        path_set[`SOA_PATH_REI_BIT] = path_remote_error_wrap;
        path_set[`SOA_PATH_B3_BIT] = path_parity_wrap;
    end

    // clears fire at capture, a cycle before the answer; a set there still wins
    always_comb begin
        path_clr = 8'h00;
        if (capture && !pwrite && hit(paddr, `SOA_IDX_PATH_STATUS)) begin
            path_clr[`SOA_PATH_MISMATCH_BIT] = 1'b1;
            path_clr[`SOA_PATH_CRC_BIT] = 1'b1;
            path_clr[`SOA_PATH_UNEQ_BIT] = 1'b1;
            path_clr[`SOA_PATH_LABEL_BIT] = 1'b1;
            path_clr[`SOA_PATH_LOM_BIT] = 1'b1;
        end
        path_clr[`SOA_PATH_RDI_BIT] = capture && !pwrite
            && hit(paddr, `SOA_IDX_RDI_FIELD);
        path_clr[`SOA_PATH_REI_BIT] = capture && !pwrite
            && hit(paddr, `SOA_IDX_CNT_REI);
        path_clr[`SOA_PATH_B3_BIT] = capture && !pwrite
            && hit(paddr, `SOA_IDX_CNT_B3);
    end

    // overrun is not reported while retiming is bypassed
    assign retime_set[0] = receive_fifo_overrun && !receive_retiming_off;
    assign retime_clr[0] = capture && !pwrite && hit(paddr, `SOA_IDX_RETIME_SRC);

    // parity count clears with the same read that clears its bit
    always_comb begin
        xmt_set = 4'h0;
        xmt_set[`SOA_XMT_NEG_BIT] = tx_negative_justify_wrap;
        xmt_set[`SOA_XMT_POS_BIT] = tx_positive_justify_wrap;
        xmt_set[`SOA_XMT_FIFO_BIT] = transmit_fifo_overrun;
        xmt_set[`SOA_XMT_PAR_BIT] = parity_evt;
        xmt_clr = 4'h0;
        xmt_clr[`SOA_XMT_NEG_BIT] = capture && !pwrite
            && hit(paddr, `SOA_IDX_CNT_TXNEG);
        xmt_clr[`SOA_XMT_POS_BIT] = capture && !pwrite
            && hit(paddr, `SOA_IDX_CNT_TXPOS);
        xmt_clr[`SOA_XMT_FIFO_BIT] = capture && !pwrite
            && hit(paddr, `SOA_IDX_XMT_SRC);
        xmt_clr[`SOA_XMT_PAR_BIT] = capture && !pwrite
            && hit(paddr, `SOA_IDX_XMT_SRC);
    end

    soa_sticky #(
        .W(8)
    ) u_path_src (
        .pclk(pclk),
        .presetn(presetn),
        .set(path_set),
        .clr(path_clr),
        .q(path_src)
    );

    soa_sticky #(
        .W(1)
    ) u_retime_src (
        .pclk(pclk),
        .presetn(presetn),
        .set(retime_set),
        .clr(retime_clr),
        .q(retime_src)
    );

    soa_sticky #(
        .W(4)
    ) u_xmt_src (
        .pclk(pclk),
        .presetn(presetn),
        .set(xmt_set),
        .clr(xmt_clr),
        .q(xmt_src)
    );

    soa_par_count u_par_count (
        .pclk(pclk),
        .presetn(presetn),
        .tx_telecom_bus_byte(tx_telecom_bus_byte),
        .tx_bus_parity(tx_bus_parity),
        .tx_bus_valid(tx_bus_valid),
        .clear(xmt_clr[`SOA_XMT_PAR_BIT]),
        .overrun_evt(parity_evt)
    );

    assign retime_byte = {7'h00, retime_src};
    assign xmt_byte = {4'h0, xmt_src};
    assign rdi_byte = {4'h0, remote_defect_field, 1'b0};
    // counter and byte sources have no status bit of their own
    assign status_byte = {status_now[4:1], 1'b0, status_now[0], 2'b00};

    // summary ignores enables so polling software sees every source
    assign summary = {|xmt_byte, |retime_byte, |path_src, |adaptation_irq_source_in,
        |protection_irq_source_in, |mux_irq_source_in, |regen_mux_irq_source_in,
        |regen_irq_source_in};

    assign pending = |(xmt_byte & st_ff.en_xmt) | |(retime_byte & st_ff.en_retime)
        | |(path_src & st_ff.en_path) | |(adaptation_irq_source_in & st_ff.en_adap)
        | |(protection_irq_source_in & st_ff.en_prot)
        | |(mux_irq_source_in & st_ff.en_mux)
        | |(regen_mux_irq_source_in & st_ff.en_rgmux)
        | |(regen_irq_source_in & st_ff.en_regen);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.primed = 1'b1;
        nxt_st.status_prev = status_now;
        nxt_st.rdi_prev = remote_defect_field;
        // one flop of lag keeps the pin free of decode glitches
        nxt_st.irq = pending;
        // counters live outside; a one-cycle pulse tells them they were read
        nxt_st.cnt_read = 4'h0;
        // read data stays in the flop until the next access captures
        if (capture) begin
            nxt_st.bus = soa_pkg::SOA_BUS_ANSWER;
            nxt_st.slverr = !mapped(paddr);
            nxt_st.rdata = 32'h0000_0000;
            if (!pwrite) begin
                nxt_st.cnt_read = {xmt_clr[`SOA_XMT_POS_BIT], xmt_clr[`SOA_XMT_NEG_BIT],
                    path_clr[`SOA_PATH_B3_BIT], path_clr[`SOA_PATH_REI_BIT]};
                if (hit(paddr, `SOA_IDX_PATH_SRC)) begin
                    nxt_st.rdata[7:0] = path_src;
                end else if (hit(paddr, `SOA_IDX_RETIME_SRC)) begin
                    nxt_st.rdata[7:0] = retime_byte;
                end else if (hit(paddr, `SOA_IDX_XMT_SRC)) begin
                    nxt_st.rdata[7:0] = xmt_byte;
                end else if (hit(paddr, `SOA_IDX_GLOBAL)) begin
                    nxt_st.rdata[7:0] = summary;
                end else if (hit(paddr, `SOA_IDX_PATH_STATUS)) begin
                    nxt_st.rdata[7:0] = status_byte;
                end else if (hit(paddr, `SOA_IDX_RDI_FIELD)) begin
                    nxt_st.rdata[7:0] = rdi_byte;
                end else if (hit(paddr, `SOA_IDX_EN_REGEN)) begin
                    nxt_st.rdata[7:0] = st_ff.en_regen;
                end else if (hit(paddr, `SOA_IDX_EN_RGMUX)) begin
                    nxt_st.rdata[7:0] = st_ff.en_rgmux;
                end else if (hit(paddr, `SOA_IDX_EN_MUX)) begin
                    nxt_st.rdata[7:0] = st_ff.en_mux;
                end else if (hit(paddr, `SOA_IDX_EN_PROT)) begin
                    nxt_st.rdata[7:0] = st_ff.en_prot;
                end else if (hit(paddr, `SOA_IDX_EN_ADAP)) begin
                    nxt_st.rdata[7:0] = st_ff.en_adap;
                end else if (hit(paddr, `SOA_IDX_EN_PATH)) begin
                    nxt_st.rdata[7:0] = st_ff.en_path;
                end else if (hit(paddr, `SOA_IDX_EN_RETIME)) begin
                    nxt_st.rdata[7:0] = st_ff.en_retime;
                end else if (hit(paddr, `SOA_IDX_EN_XMT)) begin
                    nxt_st.rdata[7:0] = st_ff.en_xmt;
                end else if (hit(paddr, `SOA_IDX_CNT_REI)) begin
                    nxt_st.rdata = cnt_word(path_remote_error_counter);
                end else if (hit(paddr, `SOA_IDX_CNT_B3)) begin
                    nxt_st.rdata = cnt_word(path_parity_error_counter);
                end else if (hit(paddr, `SOA_IDX_CNT_TXNEG)) begin
                    nxt_st.rdata = cnt_word(tx_negative_justify_counter);
                end else if (hit(paddr, `SOA_IDX_CNT_TXPOS)) begin
                    nxt_st.rdata = cnt_word(tx_positive_justify_counter);
                end
            end
        end else if (commit) begin
            nxt_st.bus = soa_pkg::SOA_BUS_IDLE;
            nxt_st.slverr = 1'b0;
            // source registers take no writes; only enables store
            if (pwrite && pstrb[0]) begin
                if (hit(paddr, `SOA_IDX_EN_REGEN)) begin
                    nxt_st.en_regen = pwdata[7:0];
                end else if (hit(paddr, `SOA_IDX_EN_RGMUX)) begin
                    nxt_st.en_rgmux = pwdata[7:0];
                end else if (hit(paddr, `SOA_IDX_EN_MUX)) begin
                    nxt_st.en_mux = pwdata[7:0];
                end else if (hit(paddr, `SOA_IDX_EN_PROT)) begin
                    nxt_st.en_prot = pwdata[7:0];
                end else if (hit(paddr, `SOA_IDX_EN_ADAP)) begin
                    nxt_st.en_adap = pwdata[7:0];
                end else if (hit(paddr, `SOA_IDX_EN_PATH)) begin
                    nxt_st.en_path = pwdata[7:0];
                end else if (hit(paddr, `SOA_IDX_EN_RETIME)) begin
                    nxt_st.en_retime = pwdata[7:0];
                end else if (hit(paddr, `SOA_IDX_EN_XMT)) begin
                    nxt_st.en_xmt = pwdata[7:0];
                end
            end
        end else begin
            nxt_st.bus = soa_pkg::SOA_BUS_IDLE;
            nxt_st.slverr = 1'b0;
        end
    end

    // enables, bus state, read data, irq and change-detect copies; source bits live in the sticky instances
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff.bus <= soa_pkg::SOA_BUS_IDLE;
            st_ff.rdata <= 32'h0000_0000;
            st_ff.slverr <= 1'b0;
            st_ff.irq <= 1'b0;
            st_ff.en_regen <= `SOA_ENABLE_RESET;
            st_ff.en_rgmux <= `SOA_ENABLE_RESET;
            st_ff.en_mux <= `SOA_ENABLE_RESET;
            st_ff.en_prot <= `SOA_ENABLE_RESET;
            st_ff.en_adap <= `SOA_ENABLE_RESET;
            st_ff.en_path <= `SOA_ENABLE_RESET;
            st_ff.en_retime <= `SOA_ENABLE_RESET;
            st_ff.en_xmt <= `SOA_ENABLE_RESET;
            st_ff.status_prev <= 5'h00;
            st_ff.rdi_prev <= 3'h0;
            st_ff.primed <= 1'b0;
            st_ff.cnt_read <= 4'h0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.rdata;
    // pready is the answer state itself, one cycle per access
    assign pready = (st_ff.bus == soa_pkg::SOA_BUS_ANSWER);
    // slverr is only ever set together with the answer state
    assign pslverr = st_ff.slverr;
    assign irq = st_ff.irq;
    assign counter_read = st_ff.cnt_read;
endmodule

// File: test/soa_irq_props.sv
// concurrent checks on the interrupt aggregator ports
`timescale 1ns/1ps
module soa_irq_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic [3:0] counter_read
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic cap;
    assign cap = psel && penable && !pready;
    chk_one_wait_state: assert property (cap |=> pready)
        else $error("access not answered one cycle after capture");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    chk_error_with_ready: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    chk_irq_reset_low: assert property (!$past(presetn) |-> !irq)
        else $error("interrupt high right after reset");
    chk_rei_read_pulse: assert property (cap && !pwrite && paddr == 12'h03c0
        |=> counter_read == 4'h1)
        else $error("remote error counter read not signalled");
    chk_txneg_read_pulse: assert property (cap && !pwrite && paddr == 12'h03c8
        |=> counter_read == 4'h4)
        else $error("negative justify counter read not signalled");
    chk_ctr_pulse_cause: assert property (counter_read != 4'h0
        |-> $past(cap && !pwrite))
        else $error("counter read pulse without a read");
    chk_ctr_pulse_single: assert property (counter_read != 4'h0
        |=> counter_read == 4'h0)
        else $error("counter read pulse too long");
endmodule
bind soa_irq_aggregator soa_irq_props soa_irq_props_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .irq(irq), .counter_read(counter_read));

// File: test/tb.sv
// self-checking bench for the interrupt aggregator
`timescale 1ns/1ps
module tb;
    logic pclk, presetn, psel, penable, pwrite, rerr, off, par, vld;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic pready, pslverr, irq;
    logic [4:0] stat;
    logic [2:0] fld;
    logic [5:0] pul;
    logic [7:0] ext [5];
    logic [7:0] tbb;
    logic [3:0] strb;
    int err_count, checks_done, cyc;
    soa_irq_aggregator soa_irq_aggregator_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .path_trace_mismatch_status(stat[0]), .path_trace_crc_status(stat[1]),
        .path_unequipped_status(stat[2]), .path_label_mismatch_status(stat[3]),
        .loss_of_multiframe_status(stat[4]), .remote_defect_field(fld),
        .path_remote_error_wrap(pul[0]), .path_parity_wrap(pul[1]),
        .receive_fifo_overrun(pul[2]), .receive_retiming_off(off),
        .tx_negative_justify_wrap(pul[3]), .tx_positive_justify_wrap(pul[4]),
        .transmit_fifo_overrun(pul[5]), .tx_telecom_bus_byte(tbb), .tx_bus_parity(par),
        .tx_bus_valid(vld), .path_remote_error_counter(16'h1234),
        .path_parity_error_counter(16'h00b3), .tx_negative_justify_counter(16'h0a0b),
        .tx_positive_justify_counter(16'h0c0d), .regen_irq_source_in(ext[0]),
        .regen_mux_irq_source_in(ext[1]), .mux_irq_source_in(ext[2]),
        .protection_irq_source_in(ext[3]), .adaptation_irq_source_in(ext[4]),
        .counter_read());
    initial begin
        pclk = 0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report;
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one access, then one idle edge so psel is never assigned twice in a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        cmp(rdat, exp);
    endtask
    task automatic pulse(input logic [5:0] m);
        pul <= m;
        @(posedge pclk) pul <= 6'h00;
        @(posedge pclk);
    endtask
    task automatic perr(input int n);
        vld <= 1'b1; par <= 1'b1;
        repeat (n) @(posedge pclk);
        vld <= 1'b0; par <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_regs;
        logic [11:0] al [11] = '{12'h294, 12'h298, 12'h2c0, 12'h2c4, 12'h2c8, 12'h2cc,
            12'h2d0, 12'h2d4, 12'h2d8, 12'h380, 12'h384};
        foreach (al[i]) rd(al[i], 32'h0000_0000);
        for (int i = 2; i < 11; i++) begin
            if (i == 9) continue;
            apb(1'b1, al[i], 32'hffff_ff5a);
            rd(al[i], 32'h0000_005a);
            apb(1'b1, al[i], 32'h0000_0000);
        end
        strb <= 4'h0;
        apb(1'b1, 12'h2c0, 32'h0000_00ff);
        strb <= 4'h1;
        rd(12'h2c0, 32'h0000_0000);
        apb(1'b1, 12'h294, 32'h0000_00ff);
        rd(12'h294, 32'h0000_0000);
        apb(1'b0, 12'h004, 32'h0000_0000);
        cmp({31'h0, rerr}, 32'h0000_0001);
    endtask
    task automatic t_path;
        stat <= 5'h1f;
        @(posedge pclk) fld <= 3'h5;
        @(posedge pclk);
        rd(12'h294, 32'h0000_00fc);
        rd(12'h314, 32'h0000_00f4);
        rd(12'h294, 32'h0000_0008);
        rd(12'h214, 32'h0000_000a);
        rd(12'h294, 32'h0000_0000);
    endtask
    task automatic t_wraps;
        pulse(6'h03);
        rd(12'h294, 32'h0000_0003);
        rd(12'h3c0, 32'h0000_1234);
        rd(12'h294, 32'h0000_0001);
        rd(12'h3c4, 32'h0000_00b3);
        rd(12'h294, 32'h0000_0000);
        pulse(6'h18);
        rd(12'h380, 32'h0000_000c);
        rd(12'h3c8, 32'h0000_0a0b);
        rd(12'h380, 32'h0000_0004);
        rd(12'h3cc, 32'h0000_0c0d);
        rd(12'h380, 32'h0000_0000);
    endtask
    task automatic t_fifo;
        off <= 1'b1;
        pulse(6'h04);
        rd(12'h298, 32'h0000_0000);
        off <= 1'b0;
        pulse(6'h04);
        rd(12'h298, 32'h0000_0001);
        rd(12'h298, 32'h0000_0000);
        pulse(6'h20);
        rd(12'h380, 32'h0000_0002);
        rd(12'h380, 32'h0000_0000);
        perr(2);
        rd(12'h380, 32'h0000_0000);
        perr(2);
        rd(12'h380, 32'h0000_0000);
        perr(3);
        rd(12'h380, 32'h0000_0001);
        rd(12'h380, 32'h0000_0000);
        tbb <= 8'h03;
        perr(3);
        rd(12'h380, 32'h0000_0000);
    endtask
    task automatic t_irq;
        pulse(6'h20);
        cmp({31'h0, irq}, 32'h0000_0000);
        rd(12'h344, 32'h0000_0080);
        foreach (ext[i]) ext[i] <= 8'h01 << i;
        @(posedge pclk);
        rd(12'h344, 32'h0000_009f);
        apb(1'b1, 12'h384, 32'h0000_0002);
        @(posedge pclk);
        cmp({31'h0, irq}, 32'h0000_0001);
        rd(12'h380, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        cmp({31'h0, irq}, 32'h0000_0000);
        apb(1'b1, 12'h2c0, 32'h0000_0001);
        @(posedge pclk);
        cmp({31'h0, irq}, 32'h0000_0001);
        foreach (ext[i]) ext[i] <= 8'h00;
        repeat (3) @(posedge pclk);
        cmp({31'h0, irq}, 32'h0000_0000);
    endtask
    task automatic final_report;
        $display("mismatches %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        off = 0; par = 0; vld = 0; stat = 0; fld = 0; pul = 0;
        tbb = 8'h01;
        strb = 4'h1;
        foreach (ext[i]) ext[i] = 8'h00;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        t_regs;
        t_path;
        t_wraps;
        t_fifo;
        t_irq;
        final_report;
    end
endmodule
